// >>> msc_defs.svh
// Constants for the motor stop configuration register
`ifndef MSC_DEFS_SVH
`define MSC_DEFS_SVH
`define MSC_CFG_INDEX     12'h08a
`define MSC_CFG_ADDR      (`MSC_CFG_INDEX << 2)
`define MSC_CFG_RESET     32'h00000000
`define MSC_PARITY_BIT    31
`define MSC_STOP_HI       30
`define MSC_STOP_LO       28
`define MSC_BRK_HI        27
`define MSC_BRK_LO        24
`define MSC_SPIN_HI       23
`define MSC_SPIN_LO       20
`define MSC_BSPD_HI       19
`define MSC_BSPD_LO       16
`define MSC_RES_HI        15
`define MSC_RES_LO        8
`define MSC_IND_HI        7
`define MSC_IND_LO        0
`define MSC_BRK_SHORT_MAX 4'h4
`define MSC_BRK_MIN_MS    14'h0001
`define MSC_PCT_FULL_PM   10'h3e8
`endif

// >>> msc_pkg.sv
// Types for the motor stop configuration register
package msc_pkg;
	typedef enum logic [2:0]
	{
		MSC_STOP_HIZ     = 3'b000,
		MSC_STOP_RECIRC  = 3'b001,
		MSC_STOP_LOWSIDE = 3'b010,
		MSC_STOP_HIGHSIDE = 3'b011,
		MSC_STOP_SPIN    = 3'b100,
		MSC_STOP_UNDEF5  = 3'b101,
		MSC_STOP_UNDEF6  = 3'b110,
		MSC_STOP_UNDEF7  = 3'b111
	} msc_stop_t;
endpackage

// >>> msc_config.sv
// APB register holding motor stop method, braking time, thresholds and motor codes
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ns
`include "msc_defs.svh"
module msc_config #(
	parameter int ADDR_W = 12
)
(
	// Clock and reset
	input  wire logic                clk,
	input  wire logic                sys_rst,
	// APB slave
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [ADDR_W-1:0]   paddr,
	input  wire logic [31:0]         pwdata,
	input  wire logic [3:0]          pstrb,
	output logic                     pready,
	output logic                     pslverr,
	output logic [31:0]              prdata,
	// Decoded configuration to the stop sequencer
	output msc_pkg::msc_stop_t       stopMethod,
	output logic                     phasesHiZ,
	output logic                     recircStop,
	output logic                     lowSideOn,
	output logic                     highSideOn,
	output logic                     activeSpinDown,
	output logic                     stopCodeUndefined,
	output logic [13:0]              brakingDurationMs,
	output logic [9:0]               spinDownThresholdPm,
	output logic [9:0]               brakeSpeedThresholdPm,
	output logic [7:0]               phaseResistanceCode,
	output logic [7:0]               phaseInductanceCode,
	output logic                     parityFlag
);
	import msc_pkg::*;

	logic [31:0]  config_ff;
	logic         pready_ff;
	logic         pslverr_ff;
	logic [31:0]  prdata_ff;
	msc_stop_t    stop_ff;
	logic [4:0]   stopOneHot_ff;
	logic         undef_ff;
	logic [13:0]  brkMs_ff;
	logic [9:0]   spinPm_ff;
	logic [9:0]   bspdPm_ff;
	logic         setup;
	logic         access;
	logic         hit;
	logic [31:0]  nxt_config;
	msc_stop_t    nxtStop;

	// Percentage scale in tenths of a percent, shared by both thresholds
	function automatic logic [9:0] pctDecode(input logic [3:0] code);
		case (code)
			4'h0: pctDecode = 10'h3e8;
			4'h1: pctDecode = 10'h384;
			4'h2: pctDecode = 10'h320;
			4'h3: pctDecode = 10'h2bc;
			4'h4: pctDecode = 10'h258;
			4'h5: pctDecode = 10'h1f4;
			4'h6: pctDecode = 10'h1c2;
			4'h7: pctDecode = 10'h190;
			4'h8: pctDecode = 10'h15e;
			4'h9: pctDecode = 10'h12c;
			4'ha: pctDecode = 10'h0fa;
			4'hb: pctDecode = 10'h0c8;
			4'hc: pctDecode = 10'h096;
			4'hd: pctDecode = 10'h064;
			4'he: pctDecode = 10'h032;
			default: pctDecode = 10'h019;
		endcase
	endfunction

	function automatic logic [13:0] msDecode(input logic [3:0] code);
		case (code)
			4'h5: msDecode = 14'h0005;
			4'h6: msDecode = 14'h000a;
			4'h7: msDecode = 14'h0032;
			4'h8: msDecode = 14'h0064;
			4'h9: msDecode = 14'h00fa;
			4'ha: msDecode = 14'h01f4;
			4'hb: msDecode = 14'h03e8;
			4'hc: msDecode = 14'h09c4;
			4'hd: msDecode = 14'h1388;
			4'he: msDecode = 14'h2710;
			4'hf: msDecode = 14'h3a98;
			default: msDecode = `MSC_BRK_MIN_MS;
		endcase
	endfunction

	assign setup  = psel && !penable;
	assign access = psel && penable && pready_ff;
	// Word index times four gives the byte address on the bus
	assign hit    = (paddr == ADDR_W'(`MSC_CFG_ADDR));

	// Byte lanes merge into the stored word
	always_comb
	begin
		nxt_config = config_ff;
		for (int i = 0; i < 4; i++)
		begin
			if (pstrb[i])
			begin
				nxt_config[8*i +: 8] = pwdata[8*i +: 8];
			end
		end
	end

	// Zero wait state: ready is raised for the access cycle during setup
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
		end
		else
		begin
			pready_ff  <= setup;
			pslverr_ff <= setup && !hit;
		end
	end

	// Read data is sampled at setup so it never disturbs the register
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			prdata_ff <= 32'h00000000;
		end
		else if (setup && !pwrite && hit)
		begin
			prdata_ff <= config_ff;
		end
		else if (setup)
		begin
			prdata_ff <= 32'h00000000;
		end
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			config_ff <= `MSC_CFG_RESET;
		end
		else if (access && pwrite && hit)
		begin
			config_ff <= nxt_config;
		end
	end

	assign nxtStop = msc_stop_t'(config_ff[`MSC_STOP_HI:`MSC_STOP_LO]);

	// Undefined stop codes fall back to floating phases, the safest drive state
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			stop_ff       <= MSC_STOP_HIZ;
			stopOneHot_ff <= 5'h01;
			undef_ff      <= 1'b0;
		end
		else
		begin
			stop_ff  <= nxtStop;
			undef_ff <= 1'b0;
			case (nxtStop)
				MSC_STOP_HIZ:      stopOneHot_ff <= 5'h01;
				MSC_STOP_RECIRC:   stopOneHot_ff <= 5'h02;
				MSC_STOP_LOWSIDE:  stopOneHot_ff <= 5'h04;
				MSC_STOP_HIGHSIDE: stopOneHot_ff <= 5'h08;
				MSC_STOP_SPIN:     stopOneHot_ff <= 5'h10;
				default:
				begin
					stopOneHot_ff <= 5'h01;
					undef_ff      <= 1'b1;
				end
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			brkMs_ff  <= `MSC_BRK_MIN_MS;
			spinPm_ff <= `MSC_PCT_FULL_PM;
			bspdPm_ff <= `MSC_PCT_FULL_PM;
		end
		else
		begin
			brkMs_ff  <= msDecode(config_ff[`MSC_BRK_HI:`MSC_BRK_LO]);
			spinPm_ff <= pctDecode(config_ff[`MSC_SPIN_HI:`MSC_SPIN_LO]);
			bspdPm_ff <= pctDecode(config_ff[`MSC_BSPD_HI:`MSC_BSPD_LO]);
		end
	end

	assign pready                = pready_ff;
	assign pslverr               = pslverr_ff;
	assign prdata                = prdata_ff;
	assign stopMethod            = stop_ff;
	assign phasesHiZ             = stopOneHot_ff[0];
	assign recircStop            = stopOneHot_ff[1];
	assign lowSideOn             = stopOneHot_ff[2];
	assign highSideOn            = stopOneHot_ff[3];
	assign activeSpinDown        = stopOneHot_ff[4];
	assign stopCodeUndefined     = undef_ff;
	assign brakingDurationMs     = brkMs_ff;
	assign spinDownThresholdPm   = spinPm_ff;
	assign brakeSpeedThresholdPm = bspdPm_ff;
	assign phaseResistanceCode   = config_ff[`MSC_RES_HI:`MSC_RES_LO];
	assign phaseInductanceCode   = config_ff[`MSC_IND_HI:`MSC_IND_LO];
	assign parityFlag            = config_ff[`MSC_PARITY_BIT];

	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	property p_resetZero;
		$past(sys_rst) |-> config_ff == `MSC_CFG_RESET;
	endproperty
	a_resetZero: assert property (p_resetZero) else $error("config not zero after reset");

	property p_fullWrite;
		access && pwrite && hit && pstrb == 4'hf |=> config_ff == $past(pwdata);
	endproperty
	a_fullWrite: assert property (p_fullWrite) else $error("full write not stored");

	property p_readBack;
		setup && !pwrite && hit ##1 access |-> prdata == config_ff;
	endproperty
	a_readBack: assert property (p_readBack) else $error("read data differs from register");

	property p_readNoEffect;
		access && !pwrite |=> $stable(config_ff);
	endproperty
	a_readNoEffect: assert property (p_readNoEffect) else $error("read changed register");

	property p_hiZ;
		config_ff[`MSC_STOP_HI:`MSC_STOP_LO] == 3'h0 ##1 $stable(config_ff) |-> phasesHiZ && !lowSideOn;
	endproperty
	a_hiZ: assert property (p_hiZ) else $error("code 0 not floating");

	property p_sides;
		config_ff[`MSC_STOP_HI:`MSC_STOP_LO] == 3'h2 |=> lowSideOn && !highSideOn;
	endproperty
	a_sides: assert property (p_sides) else $error("low side brake not decoded");

	property p_spin;
		config_ff[`MSC_STOP_HI:`MSC_STOP_LO] == 3'h4 |=> activeSpinDown && !stopCodeUndefined;
	endproperty
	a_spin: assert property (p_spin) else $error("spin down not decoded");

	property p_brkShort;
		config_ff[`MSC_BRK_HI:`MSC_BRK_LO] <= `MSC_BRK_SHORT_MAX |=> brakingDurationMs == 14'h0001;
	endproperty
	a_brkShort: assert property (p_brkShort) else $error("short brake time wrong");

	property p_spinMin;
		config_ff[`MSC_SPIN_HI:`MSC_SPIN_LO] == 4'hf |=> spinDownThresholdPm == 10'h019;
	endproperty
	a_spinMin: assert property (p_spinMin) else $error("spin threshold 2.5 percent wrong");

	property p_bspdMatch;
		config_ff[`MSC_BSPD_HI:`MSC_BSPD_LO] == config_ff[`MSC_SPIN_HI:`MSC_SPIN_LO]
			|=> brakeSpeedThresholdPm == spinDownThresholdPm;
	endproperty
	a_bspdMatch: assert property (p_bspdMatch) else $error("threshold scales differ");

	property p_codes;
		access && pwrite && hit && pstrb[1] |=> phaseResistanceCode == $past(pwdata[15:8]);
	endproperty
	a_codes: assert property (p_codes) else $error("resistance code not stored");

	c_write: cover property (access && pwrite && hit);
	c_read: cover property (access && !pwrite && hit);
	c_unmapped: cover property (access && pslverr);
	c_spin: cover property (activeSpinDown);
endmodule

// >>> msc_stage_model.sv
// Behavioural model of the three-phase power stage driven by the stop decode
`timescale 1ns/1ns
module msc_stage_model
(
	// Stop decode from the register block
	input  wire logic       phasesHiZ,
	input  wire logic       lowSideOn,
	input  wire logic       highSideOn,
	// Gate commands of the three half bridges
	output logic      [2:0] lowGate,
	output logic      [2:0] highGate
);
	// No interlock here: both brakes at once shows up as shoot-through on the gates
	always_comb
	begin
		lowGate  = (lowSideOn && !phasesHiZ) ? 3'h7 : 3'h0;
		highGate = (highSideOn && !phasesHiZ) ? 3'h7 : 3'h0;
	end
endmodule

// >>> msc_config_bench.sv
// Self-checking bench of the motor stop configuration register
`timescale 1ns/1ns
module msc_config_bench;
	import msc_pkg::*;
	localparam logic [11:0] CfgIndex = 12'h08a;
	localparam logic [11:0] CfgAddr  = CfgIndex << 2;
	logic        clk, sys_rst, psel, penable, pwrite, pready, pslverr, rdErr;
	logic        phasesHiZ, recircStop, lowSideOn, highSideOn, activeSpinDown, stopCodeUndefined, parityFlag;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rdData, w;
	logic [3:0]  pstrb, c;
	logic [13:0] brakingDurationMs;
	logic [9:0]  spinDownThresholdPm, brakeSpeedThresholdPm;
	logic [7:0]  phaseResistanceCode, phaseInductanceCode;
	logic [2:0]  lowGate, highGate;
	logic [5:0]  stopVec;
	msc_stop_t   stopMethod;
	int          errTotal, totalChecks;
	logic [13:0] brkMs [16] = '{1, 1, 1, 1, 1, 5, 10, 50, 100, 250, 500, 1000, 2500, 5000, 10000, 15000};
	logic [9:0]  thrPm [16] = '{1000, 900, 800, 700, 600, 500, 450, 400, 350, 300, 250, 200, 150, 100, 50, 25};

	msc_config #(.ADDR_W(12)) msc_config_inst (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .pslverr(pslverr),
		.prdata(prdata), .stopMethod(stopMethod), .phasesHiZ(phasesHiZ), .recircStop(recircStop),
		.lowSideOn(lowSideOn), .highSideOn(highSideOn), .activeSpinDown(activeSpinDown),
		.stopCodeUndefined(stopCodeUndefined), .brakingDurationMs(brakingDurationMs),
		.spinDownThresholdPm(spinDownThresholdPm), .brakeSpeedThresholdPm(brakeSpeedThresholdPm),
		.phaseResistanceCode(phaseResistanceCode), .phaseInductanceCode(phaseInductanceCode),
		.parityFlag(parityFlag));
	msc_stage_model msc_stage_model_inst (.phasesHiZ(phasesHiZ), .lowSideOn(lowSideOn),
		.highSideOn(highSideOn), .lowGate(lowGate), .highGate(highGate));
	assign stopVec = {phasesHiZ, recircStop, lowSideOn, highSideOn, activeSpinDown, stopCodeUndefined};

	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	task giveVerdict;
		$display("Comparisons %0d, mismatches %0d", totalChecks, errTotal);
		if (errTotal == 0 && totalChecks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		totalChecks++;
		if (seen !== exp)
		begin
			errTotal++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// Request held until pready is seen at an edge; the bound catches a dead slave
	task xfer(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (pready !== 1'b1 && n < 16);
		rdData = prdata;
		rdErr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1)
		begin
			errTotal++;
			giveVerdict();
		end
	endtask

	function automatic logic [5:0] stopFlags(input logic [2:0] code);
		case (code)
			3'h0: return 6'b100000;
			3'h1: return 6'b010000;
			3'h2: return 6'b001000;
			3'h3: return 6'b000100;
			3'h4: return 6'b000010;
			default: return 6'b100001;
		endcase
	endfunction

	initial
	begin
		sys_rst = 1'b1;
		{psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
		errTotal = 0;
		totalChecks = 0;
		repeat (6) @(posedge clk);
		sys_rst <= 1'b0;
		xfer(1'b0, CfgAddr, 32'h0, 4'h0);
		chk("reset word", rdData, 32'h0);
		chk("reset braking", brakingDurationMs, 32'h1);
		chk("reset thresholds", {spinDownThresholdPm, brakeSpeedThresholdPm}, {10'h3e8, 10'h3e8});
		// Every code of the stop, braking and threshold fields (16 values of each motor code), with the brake threshold walked in reverse
		for (int i = 0; i < 16; i++)
		begin
			c = 4'(i);
			w = {c[0], c[2:0], c, c, 4'hf - c, 8'(i * 17), 8'(255 - i)};
			xfer(1'b1, CfgAddr, w, 4'hf);
			xfer(1'b0, CfgAddr, 32'h0, 4'h0);
			chk("readback", rdData, w);
			chk("stop method", stopMethod, c[2:0]);
			chk("stop flags", stopVec, stopFlags(c[2:0]));
			chk("gates", {lowGate, highGate}, {c[2:0] == 3'h2 ? 3'h7 : 3'h0, c[2:0] == 3'h3 ? 3'h7 : 3'h0});
			chk("braking ms", brakingDurationMs, brkMs[c]);
			chk("spin thr", spinDownThresholdPm, thrPm[c]);
			chk("brake thr", brakeSpeedThresholdPm, thrPm[4'hf - c]);
			chk("motor codes", {phaseResistanceCode, phaseInductanceCode}, w[15:0]);
			chk("parity", parityFlag, c[0]);
		end
		xfer(1'b1, 12'h22c, 32'h0, 4'hf);
		chk("unmapped write err", rdErr, 1'b1);
		xfer(1'b0, 12'h22c, 32'h0, 4'h0);
		chk("unmapped read err", rdErr, 1'b1);
		chk("unmapped read", rdData, 32'h0);
		xfer(1'b1, CfgAddr, 32'h0, 4'h2);
		xfer(1'b0, CfgAddr, 32'h0, 4'h0);
		chk("lane write", rdData, w & 32'hffff00ff);
		@(posedge clk);
		sys_rst <= 1'b1;
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		xfer(1'b0, CfgAddr, 32'h0, 4'h0);
		chk("second reset", rdData, 32'h0);
		giveVerdict();
	end
endmodule
